// File: logic/tmb_bit_locate.v
// Bit reference decoder for the bit set and clear operations
`timescale 1ns/1ps
`default_nettype none
`include "tmb_defs.vh"

module tmb_bit_locate
#(
    parameter REF_W = 16
)
(
    // Operands
    input  wire [REF_W-1:0]                       bit_ref_in,
    input  wire [`TMB_BIT_LEN_W-1:0]              tbl_len_in,
    // Decoded position
    output wire [REF_W-`TMB_WORD_BITS_LOG2-1:0]   word_off_out,
    output wire [15:0]                            bit_mask_out,
    output wire                                   out_of_range_out
);

    // Word index is the reference over 16, bit index its low nibble
    assign word_off_out = bit_ref_in[REF_W-1:`TMB_WORD_BITS_LOG2];
    assign bit_mask_out = 16'h0001 << bit_ref_in[`TMB_WORD_BITS_LOG2-1:0];

    // Beyond the table when the word index reaches the length
    assign out_of_range_out =
        ({{(REF_W-`TMB_WORD_BITS_LOG2){1'b0}}, tbl_len_in} <=
         {{`TMB_BIT_LEN_W{1'b0}}, word_off_out});

endmodule // tmb_bit_locate
`default_nettype wire

// File: logic/tmb_defs.vh
// Constants shared by the table move and bit engine
`ifndef TMB_DEFS_VH
`define TMB_DEFS_VH

// Operation codes on op_code_in
`define TMB_OP_W            2
`define TMB_OP_TABLE_COPY   2'h0
`define TMB_OP_LABEL_COPY   2'h1
`define TMB_OP_BIT_SET      2'h2
`define TMB_OP_BIT_CLEAR    2'h3

// Largest table_copy_op word count (4096 words)
`define TMB_COPY_MAX        17'h01000

// Bit table geometry: 16 bits per word, length 0 to ff words
`define TMB_WORD_BITS_LOG2  4
`define TMB_BIT_LEN_W       8

// Accumulator and stack level width
`define TMB_ACC_W           32

`endif

// File: logic/tmb_engine.v
// Table move and bit engine: word copies, label copies, bit set and clear
`timescale 1ns/1ps
`default_nettype none
`include "tmb_defs.vh"

// Summary of operation
// - Table copy moves consecutive words from source table to equal-length destination.
// - Copy word count comes from stack level one, at most 4096 words.
// - Copy source start is the accumulator, a hex word address.
// - Copy destination start is the instruction operand.
// - Copy flags range error when an operand exceeds what can be handled.
// - Copy may write non-volatile word locations as destination.
// - Label copy word count comes from stack level two.
// - Label copy offset from stack level one applies to both areas.
// - Accumulator holds the label copy source: label or hex word address.
// - Label copy writes starting at the operand destination.
// - Label copy offset starts at zero; no bounds check is made.
// - Bit set forces one addressed table bit to one, others kept.
// - Bit clear forces one addressed table bit to zero, others kept.
// - Bit table length is stack level one, 0 to ff; start is accumulator.
// - Operand gives bit number from bit 0 of first word, 16 per word.
// - Bit operation flags range error when bit lies beyond length times 16.
// - Range error flag holds until scan end or next flag-driving operation.
module tmb_engine
#(
    parameter WM_AW = 16,
    parameter PM_AW = 16
)
(
    // Clock and reset
    input  wire                         mclk_in,
    input  wire                         rst_in,
    // Instruction request from the sequencer
    input  wire                         op_start_in,
    input  wire [`TMB_OP_W-1:0]         op_code_in,
    input  wire                         rung_en_in,
    input  wire                         label_to_word_in,
    input  wire [`TMB_ACC_W-1:0]        acc_in,
    input  wire [`TMB_ACC_W-1:0]        stack1_in,
    input  wire [`TMB_ACC_W-1:0]        stack2_in,
    input  wire [15:0]                  operand_in,
    input  wire                         scan_end_in,
    // Word memory port
    output reg  [WM_AW-1:0]             wm_addr_out,
    output reg                          wm_rd_out,
    output reg                          wm_wr_out,
    output reg  [15:0]                  wm_wdata_out,
    input  wire [15:0]                  wm_rdata_in,
    // Program memory data-label port
    output reg  [PM_AW-1:0]             pm_addr_out,
    output reg                          pm_rd_out,
    output reg                          pm_wr_out,
    output reg  [15:0]                  pm_wdata_out,
    input  wire [15:0]                  pm_rdata_in,
    // Status
    output reg                          busy_out,
    output reg                          done_out,
    output reg                          range_error_flag_out
);

    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_RD   = 3'h1;
    localparam [2:0] S_WAIT = 3'h2;
    localparam [2:0] S_WR   = 3'h3;
    localparam [2:0] S_FIN  = 3'h4;

    localparam AW = (WM_AW > PM_AW) ? WM_AW : PM_AW;

    reg  [2:0]          state_reg;
    reg  [AW-1:0]       src_reg;
    reg  [AW-1:0]       dst_reg;
    reg  [16:0]         left_reg;
    reg                 src_pm_reg;
    reg                 dst_pm_reg;
    reg                 bit_op_reg;
    reg                 bit_val_reg;
    reg  [15:0]         mask_reg;
    reg                 err_reg;

    wire [11:0]         bit_word_off;
    wire [15:0]         bit_mask;
    wire                bit_oor;
    wire [15:0]         rdata_sel;

    // Read data of whichever space is the source this run
    assign rdata_sel = src_pm_reg ? pm_rdata_in : wm_rdata_in;

    tmb_bit_locate
    #(
        .REF_W            (16)
    )
    u_bit_locate
    (
        .bit_ref_in       (operand_in),
        .tbl_len_in       (stack1_in[`TMB_BIT_LEN_W-1:0]),
        .word_off_out     (bit_word_off),
        .bit_mask_out     (bit_mask),
        .out_of_range_out (bit_oor)
    );

    // Last address a table would touch must fit in the word memory
    function fits_wm;
        input [`TMB_ACC_W-1:0] base;
        input [`TMB_ACC_W-1:0] count;
        reg   [`TMB_ACC_W:0]   last;
        begin
            last    = {1'b0, base} + {1'b0, count};
            fits_wm = (last <= ({{(`TMB_ACC_W+1-WM_AW){1'b0}}, {WM_AW{1'b1}}} + {{`TMB_ACC_W{1'b0}}, 1'b1}));
        end
    endfunction

    // Operand checks done at the start of an operation
    reg copy_bad;
    reg bit_bad;
    always @*
    begin
        copy_bad = 1'b0;
        bit_bad  = 1'b0;
        // Count above 4096 or a table running off the memory cannot be handled
        if ({1'b0, stack1_in[15:0]} > `TMB_COPY_MAX || stack1_in[`TMB_ACC_W-1:16] != 16'h0000)
        begin
            copy_bad = 1'b1;
        end
        if (!fits_wm(acc_in, stack1_in) || !fits_wm({16'h0000, operand_in}, stack1_in))
        begin
            copy_bad = 1'b1;
        end
        // Bit beyond table, or a non hex length / start that runs off memory
        if (bit_oor || stack1_in[`TMB_ACC_W-1:`TMB_BIT_LEN_W] != 24'h000000)
        begin
            bit_bad = 1'b1;
        end
        if (!fits_wm(acc_in, {{(`TMB_ACC_W-12){1'b0}}, bit_word_off} + {{(`TMB_ACC_W-1){1'b0}}, 1'b1}))
        begin
            bit_bad = 1'b1;
        end
    end

    // Sequencer for all operations; each word takes read, wait, write
    always @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_reg    <= S_IDLE;
            src_reg      <= {AW{1'b0}};
            dst_reg      <= {AW{1'b0}};
            left_reg     <= 17'h00000;
            src_pm_reg   <= 1'b0;
            dst_pm_reg   <= 1'b0;
            bit_op_reg   <= 1'b0;
            bit_val_reg  <= 1'b0;
            mask_reg     <= 16'h0000;
            err_reg      <= 1'b0;
            wm_addr_out  <= {WM_AW{1'b0}};
            wm_rd_out    <= 1'b0;
            wm_wr_out    <= 1'b0;
            wm_wdata_out <= 16'h0000;
            pm_addr_out  <= {PM_AW{1'b0}};
            pm_rd_out    <= 1'b0;
            pm_wr_out    <= 1'b0;
            pm_wdata_out <= 16'h0000;
            busy_out     <= 1'b0;
            done_out     <= 1'b0;
        end
        else
        begin
            done_out  <= 1'b0;
            wm_rd_out <= 1'b0;
            pm_rd_out <= 1'b0;
            wm_wr_out <= 1'b0;
            pm_wr_out <= 1'b0;
            case (state_reg)
                S_IDLE:
                begin
                    // A false rung leaves the request unexecuted
                    if (op_start_in && rung_en_in)
                    begin
                        busy_out    <= 1'b1;
                        bit_op_reg  <= 1'b0;
                        bit_val_reg <= (op_code_in == `TMB_OP_BIT_SET);
                        src_pm_reg  <= 1'b0;
                        dst_pm_reg  <= 1'b0;
                        err_reg     <= 1'b0;
                        state_reg   <= S_RD;
                        case (op_code_in)
                            `TMB_OP_TABLE_COPY:
                            begin
                                // Hex source from accumulator, dest from operand
                                src_reg  <= acc_in[AW-1:0];
                                dst_reg  <= {{(AW-16){1'b0}}, operand_in};
                                left_reg <= copy_bad ? 17'h00000 : stack1_in[16:0];
                                err_reg  <= copy_bad;
                            end
                            `TMB_OP_LABEL_COPY:
                            begin
                                // One offset added to both source and destination
                                src_reg    <= acc_in[AW-1:0] + stack1_in[AW-1:0];
                                dst_reg    <= {{(AW-16){1'b0}}, operand_in} + stack1_in[AW-1:0];
                                left_reg   <= stack2_in[16:0];
                                src_pm_reg <= label_to_word_in;
                                dst_pm_reg <= !label_to_word_in;
                            end
                            default:
                            begin
                                // Read-modify-write of the one addressed word
                                bit_op_reg <= 1'b1;
                                mask_reg   <= bit_mask;
                                src_reg    <= acc_in[AW-1:0] + {{(AW-12){1'b0}}, bit_word_off};
                                dst_reg    <= acc_in[AW-1:0] + {{(AW-12){1'b0}}, bit_word_off};
                                left_reg   <= bit_bad ? 17'h00000 : 17'h00001;
                                err_reg    <= bit_bad;
                            end
                        endcase
                    end
                end
                S_RD:
                begin
                    if (left_reg == 17'h00000)
                    begin
                        state_reg <= S_FIN;
                    end
                    else
                    begin
                        // Label source beyond the area returns whatever is there
                        wm_addr_out <= src_reg[WM_AW-1:0];
                        pm_addr_out <= src_reg[PM_AW-1:0];
                        wm_rd_out   <= !src_pm_reg;
                        pm_rd_out   <= src_pm_reg;
                        state_reg   <= S_WAIT;
                    end
                end
                S_WAIT:
                begin
                    state_reg <= S_WR;
                end
                S_WR:
                begin
                    if (dst_pm_reg)
                    begin
                        pm_addr_out  <= dst_reg[PM_AW-1:0];
                        pm_wdata_out <= rdata_sel;
                        pm_wr_out    <= 1'b1;
                    end
                    else
                    begin
                        wm_addr_out <= dst_reg[WM_AW-1:0];
                        wm_wr_out   <= 1'b1;
                        if (bit_op_reg && bit_val_reg)
                        begin
                            wm_wdata_out <= rdata_sel | mask_reg;
                        end
                        else if (bit_op_reg)
                        begin
                            wm_wdata_out <= rdata_sel & ~mask_reg;
                        end
                        else
                        begin
                            wm_wdata_out <= rdata_sel;
                        end
                    end
                    // Ascending addresses, one word at a time
                    src_reg   <= src_reg + 1'b1;
                    dst_reg   <= dst_reg + 1'b1;
                    left_reg  <= left_reg - 1'b1;
                    state_reg <= S_RD;
                end
                S_FIN:
                begin
                    busy_out  <= 1'b0;
                    done_out  <= 1'b1;
                    state_reg <= S_IDLE;
                end
                default:
                begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // Flag follows the last flag-driving operation; scan end clears it.
    // A result landing on the scan-end cycle wins so it is not lost.
    always @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            range_error_flag_out <= 1'b0;
        end
        else if (state_reg == S_FIN && (err_reg || !scan_end_in))
        begin
            range_error_flag_out <= err_reg;
        end
        else if (scan_end_in)
        begin
            range_error_flag_out <= 1'b0;
        end
    end

endmodule // tmb_engine
`default_nettype wire

// File: tb/tmb_engine_asserts.sv
// Port-level concurrent checks for the table move and bit engine
`timescale 1ns/1ps
`default_nettype none
module tmb_engine_asserts
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Requests
    input wire logic op_start_in,
    input wire logic rung_en_in,
    input wire logic scan_end_in,
    // Memory strobes and status
    input wire logic wm_rd_out,
    input wire logic wm_wr_out,
    input wire logic pm_rd_out,
    input wire logic pm_wr_out,
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic range_error_flag_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    // Handshake and enable
    property p_take;
        op_start_in && rung_en_in && !busy_out |=> busy_out [*2];
    endproperty
    a_take: assert property (p_take) else $error("accepted request not busy");
    property p_rung_off;
        op_start_in && !rung_en_in && !busy_out |=> !busy_out;
    endproperty
    a_rung_off: assert property (p_rung_off) else $error("request ran with rung low");
    property p_done_end;
        done_out |-> (!busy_out && $past(busy_out)) ##1 !done_out;
    endproperty
    a_done_end: assert property (p_done_end) else $error("done pulse or busy end wrong");
    property p_idle_mem;
        !busy_out |-> !(wm_rd_out || wm_wr_out || pm_rd_out || pm_wr_out);
    endproperty
    a_idle_mem: assert property (p_idle_mem) else $error("memory access while idle");

    // Each write carries a word read two cycles before
    property p_wm_write;
        wm_wr_out |-> $past(wm_rd_out, 2) || $past(pm_rd_out, 2);
    endproperty
    a_wm_write: assert property (p_wm_write) else $error("word write without read");
    property p_pm_write;
        pm_wr_out |-> $past(wm_rd_out, 2) && !wm_wr_out;
    endproperty
    a_pm_write: assert property (p_pm_write) else $error("label write without word read");

    // Flag moves only at an op end or after scan end
    property p_flag_rise;
        $rose(range_error_flag_out) |-> done_out;
    endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("flag rose outside op end");
    property p_flag_fall;
        $fell(range_error_flag_out) |-> done_out || $past(scan_end_in);
    endproperty
    a_flag_fall: assert property (p_flag_fall) else $error("flag fell without cause");
    property p_scan_clear;
        scan_end_in |=> !range_error_flag_out || done_out;
    endproperty
    a_scan_clear: assert property (p_scan_clear) else $error("flag kept past scan end");
endmodule // tmb_engine_asserts

bind tmb_engine tmb_engine_asserts tmb_engine_asserts_inst
(
    .mclk_in(mclk_in), .rst_in(rst_in), .op_start_in(op_start_in), .rung_en_in(rung_en_in),
    .scan_end_in(scan_end_in), .wm_rd_out(wm_rd_out), .wm_wr_out(wm_wr_out), .pm_rd_out(pm_rd_out),
    .pm_wr_out(pm_wr_out), .busy_out(busy_out), .done_out(done_out),
    .range_error_flag_out(range_error_flag_out)
);
`default_nettype wire

// File: tb/tmb_engine_tb.sv
// Self-checking bench for the table move and bit engine
`timescale 1ns/1ps
`default_nettype none
`include "tmb_defs.vh"
module tmb_engine_tb;
    logic        mclk_in, rst_in, op_start_in, rung_en_in, label_to_word_in, scan_end_in;
    logic [1:0]  op_code_in;
    logic [31:0] acc_in, stack1_in, stack2_in;
    logic [15:0] operand_in;
    wire  [15:0] wm_addr, wm_wdata, wm_rdata, pm_addr, pm_wdata, pm_rdata;
    wire         wm_rd, wm_wr, pm_rd, pm_wr, busy, done, flag;
    int          error_cnt, tests_run, i;

    tmb_engine tmb_engine_inst (.mclk_in(mclk_in), .rst_in(rst_in), .op_start_in(op_start_in),
        .op_code_in(op_code_in), .rung_en_in(rung_en_in), .label_to_word_in(label_to_word_in),
        .acc_in(acc_in), .stack1_in(stack1_in), .stack2_in(stack2_in), .operand_in(operand_in),
        .scan_end_in(scan_end_in), .wm_addr_out(wm_addr), .wm_rd_out(wm_rd), .wm_wr_out(wm_wr),
        .wm_wdata_out(wm_wdata), .wm_rdata_in(wm_rdata), .pm_addr_out(pm_addr), .pm_rd_out(pm_rd),
        .pm_wr_out(pm_wr), .pm_wdata_out(pm_wdata), .pm_rdata_in(pm_rdata), .busy_out(busy),
        .done_out(done), .range_error_flag_out(flag));
    tmb_mem_model wm_inst (.mclk_in(mclk_in), .rd_in(wm_rd), .wr_in(wm_wr), .addr_in(wm_addr),
        .wdata_in(wm_wdata), .rdata_out(wm_rdata));
    tmb_mem_model pm_inst (.mclk_in(mclk_in), .rd_in(pm_rd), .wr_in(pm_wr), .addr_in(pm_addr),
        .wdata_in(pm_wdata), .rdata_out(pm_rdata));

    // 125 MHz clock
    initial
    begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end

    task automatic chk(input string nm, input logic [15:0] exp, got);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Issue one request and wait, bounded, for its done pulse
    task automatic run_op(input logic [1:0] code, input logic dir, input logic [31:0] a, s1, s2,
                          input logic [15:0] d);
        int n;
        @(posedge mclk_in);
        #1;
        op_code_in = code;
        label_to_word_in = dir;
        acc_in = a;
        stack1_in = s1;
        stack2_in = s2;
        operand_in = d;
        op_start_in = 1'b1;
        @(posedge mclk_in);
        #1;
        op_start_in = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 20000)
        begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        chk("done", 16'h0001, {15'h0000, done});
    endtask

    task automatic t_copy;
        for (i = 0; i < 4096; i++)
            wm_inst.mem[16'h1000 + i] = 16'ha5a5 ^ i[15:0];
        wm_inst.mem[16'h5000] = 16'h1234;
        run_op(`TMB_OP_TABLE_COPY, 1'b0, 32'h1000, 32'h1000, 32'h0, 16'h3000);
        for (i = 0; i < 4096; i++)
            chk("copy word", 16'ha5a5 ^ i[15:0], wm_inst.mem[16'h3000 + i]);
        chk("copy flag", 16'h0000, {15'h0000, flag});
        run_op(`TMB_OP_TABLE_COPY, 1'b0, 32'h1000, 32'h1001, 32'h0, 16'h5000);
        chk("copy err flag", 16'h0001, {15'h0000, flag});
        chk("copy err dest", 16'h1234, wm_inst.mem[16'h5000]);
        $display("copy test done");
    endtask

    task automatic t_label;
        pm_inst.mem[16'h0042] = 16'h1111;
        pm_inst.mem[16'h0043] = 16'h2222;
        wm_inst.mem[16'h0304] = 16'hbeef;
        run_op(`TMB_OP_LABEL_COPY, 1'b1, 32'h40, 32'h2, 32'h2, 16'h0300);
        chk("label w0", 16'h1111, wm_inst.mem[16'h0302]);
        chk("label w1", 16'h2222, wm_inst.mem[16'h0303]);
        chk("label end", 16'hbeef, wm_inst.mem[16'h0304]);
        pm_inst.mem[16'h0083] = 16'h0000;
        run_op(`TMB_OP_LABEL_COPY, 1'b0, 32'h300, 32'h2, 32'h1, 16'h0080);
        chk("label back", 16'h1111, pm_inst.mem[16'h0082]);
        chk("label back end", 16'h0000, pm_inst.mem[16'h0083]);
        chk("label flag", 16'h0000, {15'h0000, flag});
        $display("label test done");
    endtask

    task automatic t_bit;
        wm_inst.mem[16'h0500] = 16'hffff;
        wm_inst.mem[16'h0501] = 16'h0000;
        wm_inst.mem[16'h0502] = 16'h0000;
        run_op(`TMB_OP_BIT_SET, 1'b0, 32'h500, 32'h2, 32'h0, 16'h001c);
        chk("set word1", 16'h1000, wm_inst.mem[16'h0501]);
        run_op(`TMB_OP_BIT_CLEAR, 1'b0, 32'h500, 32'h2, 32'h0, 16'h0000);
        chk("clear word0", 16'hfffe, wm_inst.mem[16'h0500]);
        run_op(`TMB_OP_BIT_SET, 1'b0, 32'h500, 32'h2, 32'h0, 16'h001f);
        chk("set last", 16'h9000, wm_inst.mem[16'h0501]);
        chk("set last flag", 16'h0000, {15'h0000, flag});
        run_op(`TMB_OP_BIT_SET, 1'b0, 32'h500, 32'h2, 32'h0, 16'h0020);
        chk("beyond flag", 16'h0001, {15'h0000, flag});
        chk("beyond word", 16'h0000, wm_inst.mem[16'h0502]);
        $display("bit test done");
    endtask

    task automatic t_flag;
        @(posedge mclk_in);
        #1;
        scan_end_in = 1'b1;
        @(posedge mclk_in);
        #1;
        scan_end_in = 1'b0;
        chk("scan clear", 16'h0000, {15'h0000, flag});
        run_op(`TMB_OP_BIT_SET, 1'b0, 32'h500, 32'h0, 32'h0, 16'h0000);
        chk("len0 flag", 16'h0001, {15'h0000, flag});
        run_op(`TMB_OP_BIT_CLEAR, 1'b0, 32'h500, 32'h2, 32'h0, 16'h0000);
        chk("op clear", 16'h0000, {15'h0000, flag});
        rung_en_in = 1'b0;
        op_code_in = `TMB_OP_BIT_SET;
        op_start_in = 1'b1;
        @(posedge mclk_in);
        #1;
        op_start_in = 1'b0;
        repeat (6) @(posedge mclk_in);
        #1;
        rung_en_in = 1'b1;
        chk("rung busy", 16'h0000, {15'h0000, busy});
        chk("rung word", 16'hfffe, wm_inst.mem[16'h0500]);
        $display("flag test done");
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        rst_in = 1'b1;
        op_start_in = 1'b0;
        rung_en_in = 1'b1;
        label_to_word_in = 1'b0;
        scan_end_in = 1'b0;
        op_code_in = 2'h0;
        acc_in = 32'h0;
        stack1_in = 32'h0;
        stack2_in = 32'h0;
        operand_in = 16'h0000;
        repeat (10) @(posedge mclk_in);
        #1;
        rst_in = 1'b0;
        t_copy;
        t_label;
        t_bit;
        t_flag;
        give_verdict;
    end

    // Watchdog, well past the 4096-word copy
    initial
    begin
        repeat (40000) @(posedge mclk_in);
        error_cnt++;
        give_verdict;
    end
endmodule // tmb_engine_tb
`default_nettype wire

// File: tb/tmb_mem_model.sv
// Synchronous memory model standing in for word memory or the label area
`timescale 1ns/1ps
`default_nettype none
module tmb_mem_model
(
    // Clock
    input  wire logic        mclk_in,
    // Access strobes and data
    input  wire logic        rd_in,
    input  wire logic        wr_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [15:0] wdata_in,
    // Read data
    output logic      [15:0] rdata_out
);
    logic [15:0] mem [0:65535];

    // Read data holds one cycle, then toggles so late sampling shows up
    always @(posedge mclk_in)
    begin
        if (rd_in)
            rdata_out <= mem[addr_in];
        else
            rdata_out <= ~rdata_out;
        if (wr_in)
            mem[addr_in] <= wdata_in; // Any location writable, non-volatile too
    end
endmodule // tmb_mem_model
`default_nettype wire
